//--- include/psc_defines.vh
// constants for the port statistics counter bank
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH
// indirect control word fields
`define PSC_CMD_RD      12
`define PSC_SEL_HI      11
`define PSC_SEL_LO      10
`define PSC_SEL_MIB     2'h3
`define PSC_ADDR_HI     9
// indirect address map
`define PSC_PORT_END    10'h040
`define PSC_DROP_TX1    10'h100
`define PSC_DROP_TX2    10'h101
`define PSC_DROP_RX1    10'h103
`define PSC_DROP_RX2    10'h104
// per-port word layout
`define PSC_OVF_BIT     31
`define PSC_VLD_BIT     30
`define PSC_CNT_MSB     29
`define PSC_CNT_RST     30'h0000
`define PSC_DROP_RST    16'h0000
`define PSC_SNAP_RST    32'h0000_0000
// counter offsets inside one port
`define PSC_O_RX_OCT    5'h00
`define PSC_O_SHORT_OK  2
`define PSC_O_SHORT_BAD 3
`define PSC_O_LONG_OK   4
`define PSC_O_LONG_BAD  5
`define PSC_O_BAD_SYM   6
`define PSC_O_CRC       7
`define PSC_O_ALIGN     8
`define PSC_O_CTRL      9
`define PSC_O_PAUSE     10
`define PSC_O_BCAST     11
`define PSC_O_MCAST     12
`define PSC_O_UCAST     13
`define PSC_O_BIN0      14
`define PSC_O_TX_OCT    5'h14
`define PSC_T_LATE      2
`define PSC_T_PAUSE     3
`define PSC_T_BCAST     4
`define PSC_T_MCAST     5
`define PSC_T_UCAST     6
`define PSC_T_DEFER     7
`define PSC_T_COL       8
`define PSC_T_ABORT     9
`define PSC_T_ONE       10
`define PSC_T_MANY      11
// frame length limits in octets
`define PSC_LEN_MIN     11'h040
`define PSC_LEN_127     11'h07F
`define PSC_LEN_255     11'h0FF
`define PSC_LEN_511     11'h1FF
`define PSC_LEN_1023    11'h3FF
`define PSC_LEN_MAX     11'h600
`define PSC_LEN_JUMBO   11'h77C
// collision position limit in bit times
`define PSC_LATE_BITS   10'h200
`endif

//--- verilog/psc_rx_class.v
// receive frame classifier: one increment per counter offset
`timescale 1ns/10ps
`include "psc_defines.vh"
module psc_rx_class (
    input  wire        done,
    input  wire [10:0] len,
    input  wire        crc_ok,
    input  wire        sym_err,
    input  wire        nonint,
    input  wire        bcast,
    input  wire        mcast,
    input  wire        ctrl,
    input  wire        pause_ok,
    input  wire        lo_prio,
    output reg  [19:0] inc,
    output wire [10:0] oct
);
    wire sht  = len < `PSC_LEN_MIN;
    wire lng  = len > `PSC_LEN_MAX;
    wire bad  = !crc_ok || sym_err || nonint;
    wire good = !bad;
    wire win  = !sht && len <= `PSC_LEN_JUMBO;

    assign oct = (done && lo_prio) ? len : 11'h000;

    always @* begin
        inc = 20'h0_0000;
        if (done) begin
            inc[`PSC_O_SHORT_OK]  = sht && good;
            inc[`PSC_O_SHORT_BAD] = sht && bad;
            inc[`PSC_O_LONG_OK]   = lng && good;
            inc[`PSC_O_LONG_BAD]  = lng && bad;
            inc[`PSC_O_BAD_SYM]   = sym_err && !sht && !lng;
            inc[`PSC_O_CRC]       = win && !crc_ok && !nonint;
            inc[`PSC_O_ALIGN]     = win && !crc_ok && nonint;
            inc[`PSC_O_CTRL]      = ctrl;
            inc[`PSC_O_PAUSE]     = ctrl && pause_ok && !sht && crc_ok;
            inc[`PSC_O_BCAST]     = good && bcast;
            inc[`PSC_O_MCAST]     = good && mcast && !bcast && !ctrl;
            inc[`PSC_O_UCAST]     = good && !mcast && !bcast;
            inc[`PSC_O_BIN0]      = len == `PSC_LEN_MIN;
            inc[`PSC_O_BIN0 + 1]  = len > `PSC_LEN_MIN && len <= `PSC_LEN_127;
            inc[`PSC_O_BIN0 + 2]  = len > `PSC_LEN_127 && len <= `PSC_LEN_255;
            inc[`PSC_O_BIN0 + 3]  = len > `PSC_LEN_255 && len <= `PSC_LEN_511;
            inc[`PSC_O_BIN0 + 4]  = len > `PSC_LEN_511 && len <= `PSC_LEN_1023;
            inc[`PSC_O_BIN0 + 5]  = len > `PSC_LEN_1023 && len <= `PSC_LEN_JUMBO;
        end
    end
endmodule

//--- verilog/psc_tx_class.v
// transmit frame classifier with per-frame collision tally
`timescale 1ns/10ps
`include "psc_defines.vh"
module psc_tx_class (
    input  wire        clk,
    input  wire        rst,
    input  wire        done,
    input  wire [10:0] len,
    input  wire        ok,
    input  wire        bcast,
    input  wire        mcast,
    input  wire        pause,
    input  wire        lo_prio,
    input  wire        defer,
    input  wire        col,
    input  wire [9:0]  col_bits,
    input  wire        abort,
    input  wire        half,
    output reg  [11:0] inc,
    output wire [10:0] oct
);
    reg  [1:0] ncol_reg;
    wire [1:0] ncol_now = (col && ncol_reg != 2'h2) ? ncol_reg + 2'h1 : ncol_reg;

    // tally saturates at two: only one versus several matters
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ncol_reg <= 2'h0;
        end else if (done || abort) begin
            ncol_reg <= 2'h0;
        end else begin
            ncol_reg <= ncol_now;
        end
    end

    assign oct = (done && ok && lo_prio) ? len : 11'h000;

    always @* begin
        inc = 12'h000;
        inc[`PSC_T_LATE]  = col && col_bits > `PSC_LATE_BITS;
        inc[`PSC_T_PAUSE] = done && pause;
        inc[`PSC_T_BCAST] = done && ok && bcast;
        inc[`PSC_T_MCAST] = done && ok && mcast && !bcast;
        inc[`PSC_T_UCAST] = done && ok && !mcast && !bcast;
        inc[`PSC_T_DEFER] = done && defer;
        inc[`PSC_T_COL]   = col && half;
        inc[`PSC_T_ABORT] = abort;
        inc[`PSC_T_ONE]   = done && ok && ncol_now == 2'h1;
        inc[`PSC_T_MANY]  = done && ok && ncol_now == 2'h2;
    end
endmodule

//--- verilog/psc_top.v
// port statistics counter bank with indirect read access
//
// Contract
// - keep thirty statistics counters for each of the two ports
// - bit 31 of a port counter word flags overflow, reset clear
// - bit 30 of a port counter word shows the value is valid
// - bits 29..0 hold the count, reset zero, cleared when read
// - port one at offsets 0x00-0x1F, port two at 0x20-0x3F
// - offset 0x0 adds received low-priority octets; 0x1 and 0x15 reserved
// - 0x2 short good frames, 0x3 short damaged frames
// - 0x4 long good frames, 0x5 long damaged frames, limit 1536 bytes
// - 0x6 legal-size frames holding a bad data symbol
// - 64..1916 byte bad-checksum frames: whole bytes 0x7, partial 0x8
// - 0x9 mac control frames, 0xA qualified pause frames
// - 0xB 0xC 0xD good broadcast, non-control multicast, unicast received frames
// - 0xE-0x13 received length histogram, bad frames included
// - 0x14 adds transmitted low-priority good octets, pause included
// - 0x16 counts collisions later than 512 bit times
// - 0x17-0x1A sent pause, good broadcast, multicast, unicast frames
// - 0x1B counts frames whose first attempt was deferred
// - 0x1C total collisions in half duplex only, 0x1D-0x1F excessive, single and multiple collision counts
// - drop counters are sixteen bits, reset zero, no flag bits
// - tx drops at 0x100/0x101, rx drops at 0x103/0x104
// - reading a drop counter leaves it unchanged
`timescale 1ns/10ps
`include "psc_defines.vh"
module psc_top (
    input  wire        CLK,
    input  wire        SYS_RST,
    input  wire        CTRL_WR,
    input  wire [15:0] CTRL_WDATA,
    input  wire        DATA_HI_RD,
    input  wire        DATA_LO_RD,
    output reg  [15:0] RD_DATA,
    output reg         SNAP_VALID,
    input  wire [1:0]  RX_DONE,
    input  wire [21:0] RX_LEN,
    input  wire [1:0]  RX_CRC_OK,
    input  wire [1:0]  RX_SYM_ERR,
    input  wire [1:0]  RX_NONINT,
    input  wire [1:0]  RX_BCAST,
    input  wire [1:0]  RX_MCAST,
    input  wire [1:0]  RX_CTRL,
    input  wire [1:0]  RX_PAUSE_OK,
    input  wire [1:0]  RX_LO_PRIO,
    input  wire [1:0]  TX_DONE,
    input  wire [21:0] TX_LEN,
    input  wire [1:0]  TX_OK,
    input  wire [1:0]  TX_BCAST,
    input  wire [1:0]  TX_MCAST,
    input  wire [1:0]  TX_PAUSE,
    input  wire [1:0]  TX_LO_PRIO,
    input  wire [1:0]  TX_DEFER,
    input  wire [1:0]  TX_COL,
    input  wire [19:0] TX_COL_BITS,
    input  wire [1:0]  TX_ABORT,
    input  wire [1:0]  HALF_DUPLEX,
    input  wire [1:0]  TX_DROP,
    input  wire [1:0]  RX_DROP
);

    ////////////////////////////////////////////////////////////////////////
    // state and shared signals

    localparam ST_IDLE = 1'b0;
    localparam ST_CAPT = 1'b1;

    reg         state_reg;
    reg  [9:0]  idx_reg;
    reg  [31:0] snap_reg;
    reg  [15:0] drop_reg [0:3];

    wire [63:0]   inc_all;
    wire [21:0]   rx_oct;
    wire [21:0]   tx_oct;
    wire [1919:0] cnt_flat;
    wire [63:0]   ovf_flat;
    wire [3:0]    drop_evt = {RX_DROP, TX_DROP};

    wire cmd_mib = CTRL_WR && CTRL_WDATA[`PSC_CMD_RD]
                   && CTRL_WDATA[`PSC_SEL_HI:`PSC_SEL_LO] == `PSC_SEL_MIB;
    wire in_port = idx_reg < `PSC_PORT_END;
    wire clr_go  = state_reg == ST_CAPT && in_port;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // sum with carry out; the carry marks a wrapped counter
    function [30:0] addc;
        input [29:0] cur;
        input [29:0] amt;
        begin
            addc = {1'b0, cur} + {1'b0, amt};
        end
    endfunction

    // drop counter decode; hole at 0x102 and others read zero
    function [15:0] drop_pick;
        input [9:0]  a;
        input [63:0] d;
        begin
            case (a)
                `PSC_DROP_TX1: drop_pick = d[15:0];
                `PSC_DROP_TX2: drop_pick = d[31:16];
                `PSC_DROP_RX1: drop_pick = d[47:32];
                `PSC_DROP_RX2: drop_pick = d[63:48];
                default:       drop_pick = `PSC_DROP_RST;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // frame classifiers, one pair per port

    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            wire [19:0] rinc;
            wire [11:0] tinc;

            psc_rx_class u_rx (
                .done     (RX_DONE[p]),
                .len      (RX_LEN[p*11 +: 11]),
                .crc_ok   (RX_CRC_OK[p]),
                .sym_err  (RX_SYM_ERR[p]),
                .nonint   (RX_NONINT[p]),
                .bcast    (RX_BCAST[p]),
                .mcast    (RX_MCAST[p]),
                .ctrl     (RX_CTRL[p]),
                .pause_ok (RX_PAUSE_OK[p]),
                .lo_prio  (RX_LO_PRIO[p]),
                .inc      (rinc),
                .oct      (rx_oct[p*11 +: 11])
            );

            psc_tx_class u_tx (
                .clk      (CLK),
                .rst      (SYS_RST),
                .done     (TX_DONE[p]),
                .len      (TX_LEN[p*11 +: 11]),
                .ok       (TX_OK[p]),
                .bcast    (TX_BCAST[p]),
                .mcast    (TX_MCAST[p]),
                .pause    (TX_PAUSE[p]),
                .lo_prio  (TX_LO_PRIO[p]),
                .defer    (TX_DEFER[p]),
                .col      (TX_COL[p]),
                .col_bits (TX_COL_BITS[p*10 +: 10]),
                .abort    (TX_ABORT[p]),
                .half     (HALF_DUPLEX[p]),
                .inc      (tinc),
                .oct      (tx_oct[p*11 +: 11])
            );

            // second port sits 0x20 above the first
            assign inc_all[p*32 +: 32] = {tinc, rinc};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // per-port counters: 2 ports x 32 offsets, reserved ones never move

    genvar g;
    generate
        for (g = 0; g < 64; g = g + 1) begin : g_cnt
            localparam integer OFS_I = g % 32;
            localparam integer IDX_I = g;
            localparam [4:0]   OFS   = OFS_I[4:0];
            localparam [5:0]   IDX   = IDX_I[5:0];
            localparam       PRT = g / 32;

            reg  [29:0] cnt_reg;
            reg         ovf_reg;
            wire        hit = clr_go && idx_reg[5:0] == IDX;
            wire [29:0] amt = (OFS == `PSC_O_RX_OCT) ? {19'h0_0000, rx_oct[PRT*11 +: 11]} :
                              (OFS == `PSC_O_TX_OCT) ? {19'h0_0000, tx_oct[PRT*11 +: 11]} :
                              {29'h0000_0000, inc_all[g]};
            // a read clears the old value, but an event in the same cycle still lands
            wire [30:0] nx  = addc(hit ? `PSC_CNT_RST : cnt_reg, amt);

            always @(posedge CLK or posedge SYS_RST) begin
                if (SYS_RST) begin
                    cnt_reg <= `PSC_CNT_RST;
                    ovf_reg <= 1'b0;
                end else begin
                    cnt_reg <= nx[29:0];
                    ovf_reg <= (ovf_reg && !hit) || nx[30];
                end
            end

            assign cnt_flat[g*30 +: 30] = cnt_reg;
            assign ovf_flat[g]          = ovf_reg;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // all-port drop counters: wrap silently, never cleared by reads

    integer k;
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (k = 0; k < 4; k = k + 1) begin
                drop_reg[k] <= `PSC_DROP_RST;
            end
        end else begin
            for (k = 0; k < 4; k = k + 1) begin
                if (drop_evt[k]) begin
                    drop_reg[k] <= drop_reg[k] + 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indirect read sequencer

    // the snapshot is taken one cycle after the command; until then the
    // high half shows the valid bit low, so the host simply re-reads it
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg  <= ST_IDLE;
            idx_reg    <= 10'h000;
            snap_reg   <= `PSC_SNAP_RST;
            SNAP_VALID <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_mib) begin
                        idx_reg    <= CTRL_WDATA[`PSC_ADDR_HI:0];
                        snap_reg   <= `PSC_SNAP_RST;
                        SNAP_VALID <= 1'b0;
                        state_reg  <= ST_CAPT;
                    end
                end
                ST_CAPT: begin
                    if (in_port) begin
                        snap_reg[`PSC_OVF_BIT]     <= ovf_flat[idx_reg[5:0]];
                        snap_reg[`PSC_VLD_BIT]     <= 1'b1;
                        snap_reg[`PSC_CNT_MSB:0]   <= cnt_flat[idx_reg[5:0]*30 +: 30];
                    end else begin
                        // reserved upper bits of a drop word read as zero
                        snap_reg <= {16'h0000, drop_pick(idx_reg, {drop_reg[3], drop_reg[2],
                                                                   drop_reg[1], drop_reg[0]})};
                    end
                    SNAP_VALID <= 1'b1;
                    state_reg  <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data half registers: reading them has no side effect

    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            RD_DATA <= 16'h0000;
        end else if (DATA_HI_RD) begin
            RD_DATA <= snap_reg[31:16];
        end else if (DATA_LO_RD) begin
            RD_DATA <= snap_reg[15:0];
        end
    end

endmodule

//--- tb/psc_top_assertions.sv
// checker for the indirect read interface of the counter bank
`timescale 1ns/10ps
module psc_top_assertions (
    input wire        CLK,
    input wire        SYS_RST,
    input wire        CTRL_WR,
    input wire [15:0] CTRL_WDATA,
    input wire        DATA_HI_RD,
    input wire        DATA_LO_RD,
    input wire [15:0] RD_DATA,
    input wire        SNAP_VALID
);
    reg       acc_d_reg;
    reg [9:0] off_reg;
    wire      cmd = CTRL_WR & CTRL_WDATA[12] & (CTRL_WDATA[11:10] == 2'h3);
    // a command in the capture cycle is dropped, so acceptance needs last cycle's history
    wire      acc = cmd & ~acc_d_reg;
    wire      drop = (off_reg == 10'h100) | (off_reg == 10'h101) | (off_reg == 10'h103) | (off_reg == 10'h104);
    wire      port = off_reg < 10'h040;
    wire      gap = ~port & ~drop;
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            acc_d_reg <= 1'b0;
            off_reg   <= 10'h000;
        end else begin
            acc_d_reg <= acc;
            if (acc) begin
                off_reg <= CTRL_WDATA[9:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_cmd_capture: assert property (acc |=> !SNAP_VALID ##1 SNAP_VALID)
        else $error("snapshot flag did not drop and return after a command");
    a_valid_holds: assert property (SNAP_VALID && !acc |=> SNAP_VALID)
        else $error("snapshot flag dropped without a command");
    a_fall_cause: assert property ($fell(SNAP_VALID) |-> $past(acc))
        else $error("snapshot flag fell with no accepted command");
    a_data_stands: assert property (!DATA_HI_RD && !DATA_LO_RD |=> $stable(RD_DATA))
        else $error("read data changed without a read strobe");
    a_early_invalid: assert property (acc ##1 DATA_HI_RD |=> !RD_DATA[14])
        else $error("valid bit set before capture");
    a_late_valid: assert property (port && SNAP_VALID && DATA_HI_RD && !acc |=> RD_DATA[14])
        else $error("valid bit clear on a captured port counter");
    a_drop_high: assert property (drop && DATA_HI_RD && !acc |=> RD_DATA == 16'h0000)
        else $error("drop counter high half not zero");
    a_unmapped_zero: assert property (gap && (DATA_HI_RD || DATA_LO_RD) && !acc |=> RD_DATA == 16'h0000)
        else $error("unmapped offset returned data");
    // outputs are unknown until the first edge in reset, so look one edge later
    a_reset_clear: assert property (disable iff (1'b0) SYS_RST ##1 SYS_RST |->
        RD_DATA == 16'h0000 && !SNAP_VALID)
        else $error("outputs not clear in reset");
    cover property (acc);
    cover property (drop && DATA_LO_RD);
    cover property (port && SNAP_VALID && DATA_HI_RD);
endmodule

//--- tb/psc_host.sv
// host model: issues counter read commands and collects both data halves
`timescale 1ns/10ps
module psc_host (
    input  wire        clk,
    input  wire [15:0] rd_data,
    output reg         ctrl_wr,
    output reg  [15:0] ctrl_wdata,
    output reg         hi_rd,
    output reg         lo_rd,
    output reg         to_err
);
    integer n;
    initial begin
        ctrl_wr = 1'b0;
        ctrl_wdata = 16'h0000;
        hi_rd = 1'b0;
        lo_rd = 1'b0;
        to_err = 1'b0;
    end
    // three high reads at least, so one lands after capture even for drop counters
    task read(input [9:0] off, output [31:0] w);
        begin
            w = 32'h0000_0000;
            n = 0;
            @(negedge clk);
            ctrl_wr = 1'b1;
            ctrl_wdata = {6'h07, off};
            @(negedge clk);
            ctrl_wr = 1'b0;
            ctrl_wdata = ~ctrl_wdata;
            hi_rd = 1'b1;
            while (n < 3 || (w[30] !== 1'b1 && off < 10'h040 && n < 8)) begin
                @(negedge clk);
                w[31:16] = rd_data;
                n = n + 1;
            end
            to_err = w[30] !== 1'b1 && off < 10'h040;
            hi_rd = 1'b0;
            lo_rd = 1'b1;
            @(negedge clk);
            w[15:0] = rd_data;
            lo_rd = 1'b0;
        end
    endtask
    // one control write and no data reads, for words the block must ignore
    task poke(input [15:0] v);
        begin
            @(negedge clk);
            ctrl_wr = 1'b1;
            ctrl_wdata = v;
            @(negedge clk);
            ctrl_wr = 1'b0;
        end
    endtask
endmodule

//--- tb/psc_top_tb.sv
// testbench for the port statistics counter bank
`timescale 1ns/10ps
module psc_top_tb;
    reg         CLK = 1'b0;
    reg         SYS_RST = 1'b1;
    wire        CTRL_WR, DATA_HI_RD, DATA_LO_RD, SNAP_VALID, host_to;
    wire [15:0] CTRL_WDATA, RD_DATA;
    reg  [1:0]  RX_DONE, RX_CRC_OK, RX_SYM_ERR, RX_NONINT, RX_BCAST, RX_MCAST, RX_CTRL, RX_PAUSE_OK, RX_LO_PRIO;
    reg  [1:0]  TX_DONE, TX_OK, TX_BCAST, TX_MCAST, TX_PAUSE, TX_LO_PRIO, TX_DEFER, TX_COL, TX_ABORT;
    reg  [1:0]  HALF_DUPLEX, TX_DROP, RX_DROP;
    reg  [21:0] RX_LEN, TX_LEN;
    reg  [19:0] TX_COL_BITS;
    reg  [31:0] w;
    integer     fail_count = 0;
    integer     num_checks = 0;
    integer     k;
    // expected port one counts, offset 0x00 in the top byte
    reg [255:0] tbl = 256'h4000_0101_0101_0101_0101_0101_0103_0201_0101_0102_A400_0101_0101_0101_0301_0101;
    always #12.5 CLK = ~CLK;
    psc_top i_dut (.CLK, .SYS_RST, .CTRL_WR, .CTRL_WDATA, .DATA_HI_RD, .DATA_LO_RD, .RD_DATA, .SNAP_VALID,
        .RX_DONE, .RX_LEN, .RX_CRC_OK, .RX_SYM_ERR, .RX_NONINT, .RX_BCAST, .RX_MCAST, .RX_CTRL, .RX_PAUSE_OK,
        .RX_LO_PRIO, .TX_DONE, .TX_LEN, .TX_OK, .TX_BCAST, .TX_MCAST, .TX_PAUSE, .TX_LO_PRIO, .TX_DEFER,
        .TX_COL, .TX_COL_BITS, .TX_ABORT, .HALF_DUPLEX, .TX_DROP, .RX_DROP);
    psc_host i_host (.clk(CLK), .rd_data(RD_DATA), .ctrl_wr(CTRL_WR), .ctrl_wdata(CTRL_WDATA),
        .hi_rd(DATA_HI_RD), .lo_rd(DATA_LO_RD), .to_err(host_to));
    ////////////////////////////////////////////////////////////////
    task complete_run;
        begin
            $display("checks %0d errors %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    // a host read that never sees the valid bit ends the run here
    task rd(input [9:0] off, input [31:0] exp);
        begin
            i_host.read(off, w);
            num_checks = num_checks + 1;
            if (host_to === 1'b1 || w !== exp) begin
                fail_count = fail_count + 1;
                $display("Error t=%0t got=%h exp=%h", $time, w, exp);
            end
            if (host_to === 1'b1) complete_run;
        end
    endtask
    // reads one stretch of port one offsets against the expected table
    task rd_span(input [5:0] lo, input [5:0] hi);
        begin
            for (k = lo; k <= hi; k = k + 1) begin
                rd(k[9:0], 32'h4000_0000 | tbl[255-8*k -: 8]);
            end
        end
    endtask
    // flags: lo_prio pause ctrl mcast bcast nonint sym crc_ok
    task rxf(input p, input [10:0] len, input [7:0] f);
        begin
            @(negedge CLK);
            RX_DONE[p] = 1'b1;
            RX_LEN[p*11 +: 11] = len;
            {RX_LO_PRIO[p], RX_PAUSE_OK[p], RX_CTRL[p], RX_MCAST[p], RX_BCAST[p], RX_NONINT[p], RX_SYM_ERR[p],
                RX_CRC_OK[p]} = f;
            @(negedge CLK);
            RX_DONE = 2'b00;
        end
    endtask
    // flags: defer lo_prio pause mcast bcast ok
    task txf(input [10:0] len, input [5:0] f);
        begin
            @(negedge CLK);
            TX_DONE = 2'b01;
            TX_LEN[10:0] = len;
            {TX_DEFER[0], TX_LO_PRIO[0], TX_PAUSE[0], TX_MCAST[0], TX_BCAST[0], TX_OK[0]} = f;
            @(negedge CLK);
            TX_DONE = 2'b00;
        end
    endtask
    task col(input [9:0] bits);
        begin
            @(negedge CLK);
            TX_COL = 2'b01;
            TX_COL_BITS[9:0] = bits;
            @(negedge CLK);
            TX_COL = 2'b00;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task port_one_counts;
        begin
            rxf(0, 11'd64, 8'h89);
            rxf(0, 11'd40, 8'h01);
            rxf(0, 11'd40, 8'h00);
            rxf(0, 11'd1600, 8'h01);
            rxf(0, 11'd1600, 8'h00);
            rxf(0, 11'd100, 8'h03);
            rxf(0, 11'd200, 8'h04);
            rxf(0, 11'd64, 8'h71);
            rxf(0, 11'd300, 8'h11);
            rxf(0, 11'd600, 8'h01);
            col(10'h064);
            txf(11'd100, 6'h11);
            col(10'h258);
            col(10'h032);
            txf(11'd64, 6'h1D);
            txf(11'd80, 6'h23);
            @(negedge CLK);
            TX_ABORT = 2'b01;
            @(negedge CLK);
            TX_ABORT = 2'b00;
            rd_span(6'h00, 6'h05);
            rd_span(6'h06, 6'h0D);
            rd_span(6'h0E, 6'h15);
            rd_span(6'h16, 6'h1F);
        end
    endtask
    task port_two_and_clear;
        begin
            rxf(1, 11'd64, 8'h01);
            rd(10'h02E, 32'h4000_0001);
            rd(10'h00E, 32'h4000_0000);
            rd(10'h02E, 32'h4000_0000);
            // other tables and write words must not capture or clear the counter
            rxf(0, 11'd64, 8'h01);
            i_host.poke(16'h100E);
            i_host.poke(16'h0C0E);
            rd(10'h00E, 32'h4000_0001);
            // full duplex: no collision total; exactly 512 bit times is not late
            HALF_DUPLEX = 2'b10;
            col(10'h200);
            col(10'h258);
            HALF_DUPLEX = 2'b11;
            rd(10'h016, 32'h4000_0001);
            rd(10'h01C, 32'h4000_0000);
        end
    endtask
    task drop_counts;
        begin
            @(negedge CLK);
            TX_DROP = 2'b11;
            RX_DROP = 2'b01;
            @(negedge CLK);
            TX_DROP = 2'b01;
            RX_DROP = 2'b11;
            @(negedge CLK);
            TX_DROP = 2'b00;
            RX_DROP = 2'b00;
            rd(10'h100, 32'h0000_0002);
            rd(10'h101, 32'h0000_0001);
            rd(10'h103, 32'h0000_0002);
            rd(10'h104, 32'h0000_0001);
            rd(10'h100, 32'h0000_0002);
            rd(10'h102, 32'h0000_0000);
            rd(10'h040, 32'h0000_0000);
        end
    endtask
    task reset_again;
        begin
            rxf(0, 11'd64, 8'h01);
            @(negedge CLK);
            SYS_RST = 1'b1;
            repeat (2) @(negedge CLK);
            SYS_RST = 1'b0;
            rd(10'h00E, 32'h4000_0000);
            rd(10'h103, 32'h0000_0000);
        end
    endtask
    initial begin
        {RX_DONE, RX_CRC_OK, RX_SYM_ERR, RX_NONINT, RX_BCAST, RX_MCAST, RX_CTRL, RX_PAUSE_OK, RX_LO_PRIO} = 18'h0_0000;
        {TX_DONE, TX_OK, TX_BCAST, TX_MCAST, TX_PAUSE, TX_LO_PRIO, TX_DEFER, TX_COL, TX_ABORT} = 18'h0_0000;
        {TX_DROP, RX_DROP} = 4'h0;
        HALF_DUPLEX = 2'b11;
        RX_LEN = 22'h00_0000;
        TX_LEN = 22'h00_0000;
        TX_COL_BITS = 20'h0_0000;
        repeat (4) @(negedge CLK);
        SYS_RST = 1'b0;
        port_one_counts;
        port_two_and_clear;
        drop_counts;
        reset_again;
        complete_run;
    end
endmodule
bind psc_top psc_top_assertions i_chk (.CLK, .SYS_RST, .CTRL_WR, .CTRL_WDATA, .DATA_HI_RD, .DATA_LO_RD,
    .RD_DATA, .SNAP_VALID);
